// ---- backplane_buffer_control.sv ----
// Buffer control outputs for a multiplexed backplane address/data interface.
//
// Summary of operation
// - Address load clock changes on start-cycle sample edge
// - Mux select rests high; low means address
// - Master: mux select low one period from start
// - Master write: bus enable held until acknowledge
// - Master read: bus enable held one cycle
// - Slave read: bus enable on acknowledge cycle
// - Slave address enable low after grant asserts
// - Early grant: address enable at first sample
// - Master read: data clock on ack or interim
// - Slave write: data clock when grant asserts
// - Block write: first data clock high two cycles
// - Block write, early grant: clock after start
// - Interim ack request gives one-cycle data pulse
// - Local ack gives final block data pulse
// - Master read: data enable until hold released
// - Slave write: data enable follows grant edges
// - Slave enables only with grant, once requested
// - Interim ack request drives transfer mode zero
`timescale 1ns/1ps
module backplane_buffer_control (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Backplane pins
  input wire core_pkg::bus_pins_s bus_pins,
  // Local control and controller status
  input wire core_pkg::local_ctl_s local_ctl,
  // Transceiver control
  output logic addr_load_clk,
  output logic data_load_clk,
  output logic mux_sel,
  output logic bus_out_enable_n,
  output logic local_addr_enable_n,
  output logic local_data_enable_n,
  // Transfer mode zero, open drain
  output logic tm0_out,
  output logic tm0_oe
);
  import core_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisation and bus clock edges
  // ----------------------------------------------------------------
  bus_pins_s bp;
  local_ctl_s lc;
  logic bclk_q;
  logic fall;
  logic rise;
  logic hold_idle;

  sync_stage #(
    .WIDTH($bits(bus_pins_s)),
    .INIT({$bits(bus_pins_s){1'b1}})
  ) u_sync_bus (
    .core_clk(core_clk),
    .rst(rst),
    .din(bus_pins),
    .dout(bp)
  );

  sync_stage #(
    .WIDTH($bits(local_ctl_s)),
    .INIT(10'h0F)
  ) u_sync_local (
    .core_clk(core_clk),
    .rst(rst),
    .din(local_ctl),
    .dout(lc)
  );

  always_ff @(posedge core_clk) begin
    if (rst) begin
      bclk_q <= 1'b1;
    end else begin
      bclk_q <= bp.bus_clk;
    end
  end

  assign fall = bclk_q & ~bp.bus_clk;
  assign rise = ~bclk_q & bp.bus_clk;
  assign hold_idle = rst | ~bp.bus_reset_n;

  // ----------------------------------------------------------------
  // Bus cycle decode, valid only at the sample edge
  // ----------------------------------------------------------------
  logic start_cyc;
  logic ack_cyc;
  logic interim_cyc;
  logic m_start_edge;

  assign start_cyc = fall & ~bp.start_n & bp.ack_n;
  assign ack_cyc = fall & ~bp.ack_n & bp.start_n;
  assign interim_cyc = fall & ~bp.tm0_n & bp.ack_n & bp.start_n;

  // ----------------------------------------------------------------
  // Master sequence
  // ----------------------------------------------------------------
  master_state_e mstate;
  master_state_e next_mstate;

  assign m_start_edge = rise & lc.master_start & (mstate == M_IDLE);

  always_comb begin
    next_mstate = mstate;
    case (mstate)
      M_IDLE: if (m_start_edge) next_mstate = M_ADDR;
      M_ADDR: if (rise) next_mstate = M_DATA;
      M_DATA: if (ack_cyc) next_mstate = lc.master_write ? M_DONE : M_HOLD;
      M_DONE: if (rise) next_mstate = M_IDLE;
      M_HOLD: if (fall & lc.master_hold_n) next_mstate = M_IDLE;
      default: next_mstate = M_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (hold_idle) begin
      mstate <= M_IDLE;
    end else begin
      mstate <= next_mstate;
    end
  end

  // ----------------------------------------------------------------
  // Slave sequence
  // ----------------------------------------------------------------
  slave_state_e sstate;
  slave_state_e next_sstate;

  always_comb begin
    next_sstate = sstate;
    case (sstate)
      S_IDLE: if (fall & lc.slave_selected) begin
        next_sstate = lc.slave_grant_access_n ? S_WAIT : S_GRANT;
      end
      S_WAIT: if (fall & ~lc.slave_grant_access_n) next_sstate = S_GRANT;
      S_GRANT: if (fall & lc.slave_grant_access_n) next_sstate = S_IDLE;
      default: next_sstate = S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (hold_idle) begin
      sstate <= S_IDLE;
    end else begin
      sstate <= next_sstate;
    end
  end

  logic grant_entry;
  logic block_wr;
  assign grant_entry = (sstate != S_GRANT) & (next_sstate == S_GRANT);
  assign block_wr = lc.slave_write & lc.slave_block;

  // ----------------------------------------------------------------
  // Address path
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (hold_idle) begin
      addr_load_clk <= LOAD_IDLE;
    end else if (fall) begin
      addr_load_clk <= start_cyc ? LOAD_ACTIVE : LOAD_IDLE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (hold_idle) begin
      mux_sel <= SEL_DATA;
    end else if (m_start_edge) begin
      mux_sel <= SEL_ADDR;
    end else if (rise) begin
      mux_sel <= SEL_DATA;
    end
  end

  always_ff @(posedge core_clk) begin
    if (hold_idle) begin
      local_addr_enable_n <= EN_OFF;
    end else if (fall) begin
      local_addr_enable_n <= (next_sstate == S_GRANT) ? EN_ON : EN_OFF;
    end
  end

  // ----------------------------------------------------------------
  // Bus output enable
  // ----------------------------------------------------------------
  logic ack_arm;

  always_ff @(posedge core_clk) begin
    if (hold_idle) begin
      ack_arm <= 1'b0;
    end else if (fall) begin
      ack_arm <= (sstate == S_GRANT) & ~lc.local_ack_n & ~lc.slave_write;
    end else if (rise) begin
      ack_arm <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (hold_idle) begin
      bus_out_enable_n <= EN_OFF;
    end else if (m_start_edge) begin
      bus_out_enable_n <= EN_ON;
    end else if (rise & (mstate == M_ADDR) & ~lc.master_write) begin
      bus_out_enable_n <= EN_OFF;
    end else if (rise & (mstate == M_DONE)) begin
      bus_out_enable_n <= EN_OFF;
    end else if (rise & ack_arm) begin
      bus_out_enable_n <= EN_ON;
    end else if (rise & (mstate == M_IDLE)) begin
      bus_out_enable_n <= EN_OFF;
    end
  end

  // ----------------------------------------------------------------
  // Data load clock
  // ----------------------------------------------------------------
  logic [1:0] data_load_clk_left;
  logic [1:0] next_load;

  always_comb begin
    next_load = PULSE_NONE;
    if ((mstate == M_DATA) & ~lc.master_write) begin
      if (ack_cyc | (lc.master_block & interim_cyc)) begin
        next_load = PULSE_HIGH;
      end
    end else if (grant_entry & lc.slave_write) begin
      next_load = block_wr ? FIRST_BLOCK_HIGH : PULSE_HIGH;
    end else if ((sstate == S_GRANT) & block_wr & (data_load_clk_left == PULSE_NONE)) begin
      if (~lc.slave_interim_ack_n | ~lc.local_ack_n) begin
        next_load = PULSE_HIGH;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (hold_idle) begin
      data_load_clk_left <= PULSE_NONE;
      data_load_clk <= LOAD_IDLE;
    end else if (fall) begin
      if (next_load != PULSE_NONE) begin
        data_load_clk_left <= next_load - PULSE_HIGH;
        data_load_clk <= LOAD_ACTIVE;
      end else if (data_load_clk_left != PULSE_NONE) begin
        data_load_clk_left <= data_load_clk_left - PULSE_HIGH;
        data_load_clk <= LOAD_ACTIVE;
      end else begin
        data_load_clk <= LOAD_IDLE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Local data enable
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (hold_idle) begin
      local_data_enable_n <= EN_OFF;
    end else if (fall) begin
      if (next_mstate == M_HOLD) begin
        local_data_enable_n <= EN_ON;
      end else if ((next_sstate == S_GRANT) & lc.slave_write) begin
        local_data_enable_n <= EN_ON;
      end else begin
        local_data_enable_n <= EN_OFF;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interim acknowledge on transfer mode zero
  // ----------------------------------------------------------------
  logic tm0_arm;

  always_ff @(posedge core_clk) begin
    if (hold_idle) begin
      tm0_arm <= 1'b0;
    end else if (fall) begin
      tm0_arm <= (sstate == S_GRANT) & lc.slave_block & ~lc.slave_interim_ack_n;
    end else if (rise) begin
      tm0_arm <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (hold_idle) begin
      tm0_oe <= 1'b0;
      tm0_out <= 1'b0;
    end else if (rise) begin
      tm0_oe <= tm0_arm;
      tm0_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_addr_clk;
    @(posedge core_clk) disable iff (hold_idle)
    start_cyc |=> addr_load_clk;
  endproperty
  a_addr_clk: assert property (p_addr_clk) else $error("address load clock missed start");
  property p_mux_low;
    @(posedge core_clk) disable iff (hold_idle)
    m_start_edge |=> (mux_sel == SEL_ADDR) && (mstate == M_ADDR);
  endproperty
  a_mux_low: assert property (p_mux_low) else $error("mux select not low at start");
  property p_mux_rest;
    @(posedge core_clk) disable iff (hold_idle)
    (mux_sel == SEL_ADDR) && rise && (mstate == M_ADDR) |=> (mux_sel == SEL_DATA);
  endproperty
  a_mux_rest: assert property (p_mux_rest) else $error("mux select held past one period");
  property p_wr_enable;
    @(posedge core_clk) disable iff (hold_idle)
    (mstate == M_DATA) && lc.master_write && $past(mstate == M_DATA)
      |-> (bus_out_enable_n == EN_ON);
  endproperty
  a_wr_enable: assert property (p_wr_enable) else $error("write enable dropped before ack");
  property p_rd_enable;
    @(posedge core_clk) disable iff (hold_idle)
    rise && (mstate == M_ADDR) && !lc.master_write |=> (bus_out_enable_n == EN_OFF);
  endproperty
  a_rd_enable: assert property (p_rd_enable) else $error("read enable longer than a cycle");
  property p_aen_on;
    @(posedge core_clk) disable iff (hold_idle)
    fall && (sstate == S_WAIT) && !lc.slave_grant_access_n
      |=> (local_addr_enable_n == EN_ON) ##1 (sstate == S_GRANT);
  endproperty
  a_aen_on: assert property (p_aen_on) else $error("address enable late after grant");
  property p_aen_off;
    @(posedge core_clk) disable iff (hold_idle)
    fall && (sstate == S_GRANT) && lc.slave_grant_access_n
      |=> (local_addr_enable_n == EN_OFF) && (sstate == S_IDLE);
  endproperty
  a_aen_off: assert property (p_aen_off) else $error("address enable not released");
  property p_block_first;
    @(posedge core_clk) disable iff (hold_idle)
    fall && grant_entry && block_wr |=> data_load_clk && (data_load_clk_left == PULSE_HIGH);
  endproperty
  a_block_first: assert property (p_block_first) else $error("first block pulse wrong");
  property p_den_hold;
    @(posedge core_clk) disable iff (hold_idle)
    (mstate == M_HOLD) && $past(mstate == M_HOLD) |-> (local_data_enable_n == EN_ON);
  endproperty
  a_den_hold: assert property (p_den_hold) else $error("data enable dropped during hold");
  property p_tm0;
    @(posedge core_clk) disable iff (hold_idle)
    rise && tm0_arm |=> tm0_oe;
  endproperty
  a_tm0: assert property (p_tm0) else $error("interim ack not driven");
  property p_reset_idle;
    @(posedge core_clk)
    hold_idle |=> (bus_out_enable_n == EN_OFF) && (local_addr_enable_n == EN_OFF)
      && (local_data_enable_n == EN_OFF) && (mux_sel == SEL_DATA) && !tm0_oe
      && (addr_load_clk == LOAD_IDLE) && (data_load_clk == LOAD_IDLE);
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle in reset");

endmodule

// ---- backplane_buffer_control_tb_top.sv ----
// Self-checking bench for the backplane buffer control block.
`timescale 1ns/1ps
module backplane_buffer_control_tb_top;
  import core_pkg::*;

`define CHECK(name, exp, got) begin \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("[FAIL] %s expected %h seen %h", name, exp, got); \
  end \
end

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  local_ctl_s local_ctl = local_ctl_s'(10'h00F);
  logic [1:0] cycle_kind = 2'h0;
  logic hold_reset = 1'b0;
  bus_pins_s bus_pins;
  logic addr_load_clk;
  logic data_load_clk;
  logic mux_sel;
  logic bus_out_enable_n;
  logic local_addr_enable_n;
  logic local_data_enable_n;
  logic tm0_out;
  logic tm0_oe;
  logic [7:0] seen;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  assign seen = {addr_load_clk, data_load_clk, mux_sel, bus_out_enable_n,
                 local_addr_enable_n, local_data_enable_n, tm0_oe, tm0_out};

  always #20 core_clk = ~core_clk;

  backplane_model i_backplane_model (
    .core_clk(core_clk),
    .cycle_kind(cycle_kind),
    .hold_reset(hold_reset),
    .bus_pins(bus_pins)
  );

  backplane_buffer_control i_backplane_buffer_control (
    .core_clk(core_clk),
    .rst(rst),
    .bus_pins(bus_pins),
    .local_ctl(local_ctl),
    .addr_load_clk(addr_load_clk),
    .data_load_clk(data_load_clk),
    .mux_sel(mux_sel),
    .bus_out_enable_n(bus_out_enable_n),
    .local_addr_enable_n(local_addr_enable_n),
    .local_data_enable_n(local_data_enable_n),
    .tm0_out(tm0_out),
    .tm0_oe(tm0_oe)
  );

  // ----------------------------------------------------------------
  // One bus period per row: cycle kind, local control, after rise, after fall
  // ----------------------------------------------------------------
  // Output byte order: address load, data load, select, bus enable, address enable,
  // data enable, transfer mode drive, transfer mode level.
  logic [31:0] rows [29] = '{
    32'h0_00F_3C_3C, 32'h0_30F_3C_3C,
    32'h1_10F_0C_8C,
    32'h0_10F_AC_2C,
    32'h2_10F_2C_2C,
    32'h0_00F_3C_3C, 32'h0_28E_3C_3C, 32'h1_08E_0C_8C,
    32'h3_08E_BC_7C,
    32'h2_08E_7C_78, 32'h0_08E_78_38,
    32'h0_00F_38_3C,
    32'h1_007_3C_BC,
    32'h0_007_BC_3C, 32'h1_06F_3C_BC,
    32'h0_067_BC_70,
    32'h0_067_70_30,
    32'h0_06F_30_3C,
    32'h1_077_3C_F0,
    32'h0_077_F0_70,
    32'h0_077_70_30,
    32'h0_073_30_70,
    32'h0_077_72_32,
    32'h0_075_30_70,
    32'h0_07F_70_3C, 32'h1_047_3C_B4, 32'h0_045_B4_34,
    32'h0_04F_24_2C,
    32'h0_00F_3C_3C
  };

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Inputs change two core clocks after the bus clock rises, so they are steady
  // at both synchronised bus clock edges of the period.
  task automatic run_row(input logic [31:0] r, input logic bus_rst);
    @(posedge bus_pins.bus_clk);
    repeat (2) @(posedge core_clk);
    cycle_kind <= r[29:28];
    local_ctl <= local_ctl_s'(r[25:16]);
    hold_reset <= bus_rst;
    repeat (5) @(posedge core_clk);
    #1;
    `CHECK("outputs after rise", r[15:8], seen)
    repeat (2) @(posedge core_clk);
    #1;
    `CHECK("outputs after fall", r[7:0], seen)
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      run_row(rows[i], 1'b0);
    end
    $display("test row table done");
    // Core reset in mid master start must drop select and enable at once.
    run_row(32'h0_30F_3C_3C, 1'b0);
    @(posedge bus_pins.bus_clk);
    repeat (2) @(posedge core_clk);
    cycle_kind <= 2'h1;
    local_ctl <= local_ctl_s'(10'h10F);
    repeat (5) @(posedge core_clk);
    #1;
    `CHECK("select before reset", 8'h0C, seen)
    @(posedge core_clk);
    rst <= 1'b1;
    // The bus goes quiet with the reset so that no start cycle is pending at release.
    cycle_kind <= 2'h0;
    local_ctl <= local_ctl_s'(10'h00F);
    @(posedge core_clk);
    #1;
    `CHECK("outputs in core reset", 8'h3C, seen)
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    run_row(32'h0_00F_3C_3C, 1'b0);
    $display("test core reset done");
    // Bus reset masks a start cycle with grant already given.
    run_row(32'h1_067_3C_3C, 1'b1);
    run_row(32'h0_00F_3C_3C, 1'b1);
    run_row(32'h0_00F_3C_3C, 1'b0);
    $display("test bus reset done");
    tally_and_finish();
  end

  // A run of about 400 core clocks is expected; the ceiling leaves ample room.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      tally_and_finish();
    end
  end
endmodule

// ---- backplane_model.sv ----
// Far-side backplane model: free-running bus clock and bus cycle lines.
`timescale 1ns/1ps
module backplane_model (
  // Clock
  input wire logic core_clk,
  // Requests from the bench
  input wire logic [1:0] cycle_kind,
  input wire logic hold_reset,
  // Backplane pins
  output core_pkg::bus_pins_s bus_pins
);
  import core_pkg::*;

  // ----------------------------------------------------------------
  // Bus clock: ten core clocks a period, rising as phase becomes zero
  // ----------------------------------------------------------------
  logic [3:0] phase = 4'h0;
  logic clk_pin = 1'b0;
  logic start_pin = 1'b1;
  logic ack_pin = 1'b1;
  logic tm0_pin = 1'b1;

  always_ff @(posedge core_clk) begin
    phase <= (phase == 4'h9) ? 4'h0 : phase + 4'h1;
  end

  always_ff @(posedge core_clk) begin
    if (phase == 4'h9) begin
      clk_pin <= 1'b1;
    end else if (phase == 4'h4) begin
      clk_pin <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Cycle lines
  // ----------------------------------------------------------------
  // Lines move well clear of both bus clock edges; released lines sit at the pull-up level.
  always_ff @(posedge core_clk) begin
    if (phase == 4'h2) begin
      start_pin <= (cycle_kind != 2'h1);
      ack_pin <= (cycle_kind != 2'h2);
      tm0_pin <= (cycle_kind != 2'h3);
    end
  end

  assign bus_pins = {clk_pin, ~hold_reset, start_pin, ack_pin, tm0_pin};
endmodule

// ---- core_pkg.sv ----
// Shared types and constants for the backplane buffer control block.
package core_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CORE_CLK_HZ = 25_000_000;
  localparam int SYNC_STAGES = 2;
  localparam logic [1:0] FIRST_BLOCK_HIGH = 2'h2;
  localparam logic [1:0] PULSE_HIGH = 2'h1;
  localparam logic [1:0] PULSE_NONE = 2'h0;

  // ----------------------------------------------------------------
  // Output idle and active levels
  // ----------------------------------------------------------------
  localparam logic LOAD_IDLE = 1'b0;
  localparam logic LOAD_ACTIVE = 1'b1;
  localparam logic EN_OFF = 1'b1;
  localparam logic EN_ON = 1'b0;
  localparam logic SEL_DATA = 1'b1;
  localparam logic SEL_ADDR = 1'b0;

  // ----------------------------------------------------------------
  // State machines
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_ADDR = 3'b001,
    M_DATA = 3'b010,
    M_DONE = 3'b011,
    M_HOLD = 3'b100
  } master_state_e;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_WAIT = 2'b01,
    S_GRANT = 2'b10
  } slave_state_e;

  // ----------------------------------------------------------------
  // Pin groups
  // ----------------------------------------------------------------
  typedef struct packed {
    logic bus_clk;
    logic bus_reset_n;
    logic start_n;
    logic ack_n;
    logic tm0_n;
  } bus_pins_s;

  typedef struct packed {
    logic master_start;
    logic master_write;
    logic master_block;
    logic slave_selected;
    logic slave_write;
    logic slave_block;
    logic slave_grant_access_n;
    logic slave_interim_ack_n;
    logic local_ack_n;
    logic master_hold_n;
  } local_ctl_s;

endpackage

// ---- sync_stage.sv ----
// Two flip-flop synchroniser for a group of asynchronous inputs.
`timescale 1ns/1ps
module sync_stage #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta <= INIT;
      dout <= INIT;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule
